// ### rtl/ssf_feedback.sv
// SPI slave that returns status feedback frames for four status commands.
// Assumes SPI mode 0: SI sampled on SCLK rise, SO advanced on SCLK fall,
// SCLK much slower than clk_sys. Diagnosis inputs come from clk_sys logic.
// What this block does
// - Snapshot response at frame end, hold stable
// - Short diag: parity, five zeros, ten flags
// - Channel flag ORs all faults, zero normal
// - Register write frame returns short diagnosis
// - Status frame: parity, seven zeros, status byte
// - Bits 0/1 flag faults channels 1-6/7-10
// - Bits 2/3 report digital/analog undervoltage
// - Bit 4 reports earlier frame counter error
// - Bit 5 reports earlier ignored bad command
// - Status bits 6 and 7 read zero
// - Pattern check echoes its own command code
// - Input readback: parity, zeros, ten pin levels
// - Pins sampled at chip select falling edge
// - Readback bit equals pin level high/low
// - Feedback goes out in the following frame
// - Low four command bits select the command
// - Undefined command ignored, logged as error
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module ssf_feedback (
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // SPI pins
   input  wire logic        spi_sclk,
   input  wire logic        spi_cs_b,
   input  wire logic        spi_si,
   output      logic        spi_so,
   output      logic        spi_so_oe,
   // Parallel inputs and supply monitors
   input  wire logic [9:0]  parallel_control_inputs,
   input  wire logic        supply_uv_digital,
   input  wire logic        supply_uv_analog,
   // Per-channel diagnosis conditions
   input  wire logic [9:0]  diag_open_load,
   input  wire logic [9:0]  diag_overcurrent,
   input  wire logic [9:0]  diag_overtemp,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output      logic [15:0] reg_rdata,
   // Interrupt
   output      logic        irq
);

   ssf_pkg::ssf_pins_t   pins_raw;
   ssf_pkg::ssf_pins_t   pins_s;
   ssf_pkg::ssf_status_t status_now;
   ssf_pkg::ssf_resp_t   resp_kind_d;
   ssf_pkg::ssf_resp_t   pend_kind_q;

   logic        sclk_prev_q;
   logic        cs_prev_q;
   logic        uv_prev_q;
   logic [15:0] rx_q;
   logic [15:0] rx_last_q;
   logic [4:0]  bit_cnt_q;
   logic [15:0] tx_q;
   logic [14:0] pend_word_q;
   logic        frame_cnt_err_q;
   logic        link_err_q;
   logic [3:0]  irq_stat_q;
   logic [3:0]  irq_stat_d;
   logic [3:0]  irq_mask_q;

   // Pin synchronisation
   assign pins_raw = {spi_sclk, spi_cs_b, spi_si, supply_uv_digital,
                      supply_uv_analog, parallel_control_inputs};

   ssf_sync #(
      .WIDTH   ($bits(ssf_pkg::ssf_pins_t)),
      .RST_VAL (ssf_pkg::PINS_RST)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d       (pins_raw),
      .q       (pins_s)
   );

   // Edge detection on the synchronised pins
   wire in_frame  = ~pins_s.cs_b;
   wire cs_fall   = ~pins_s.cs_b & cs_prev_q;
   wire cs_rise   = pins_s.cs_b & ~cs_prev_q;
   wire sclk_rise = pins_s.sclk & ~sclk_prev_q & in_frame;
   wire sclk_fall = ~pins_s.sclk & sclk_prev_q & in_frame;
   wire uv_now    = pins_s.uv_dig | pins_s.uv_ana;

   // Received frame decode
   wire [2:0] rx_addr   = rx_q[14:12];
   wire [3:0] rx_tag    = rx_q[11:8];
   wire [3:0] grp_b     = rx_q[7:4];
   wire [3:0] grp_a     = rx_q[3:0];
   wire       frame_ok  = (bit_cnt_q == ssf_pkg::CNT_FULL);
   wire       is_cmd    = (rx_addr == ssf_pkg::ADDR_CMD);
   wire       is_write  = (rx_addr >= ssf_pkg::ADDR_FIRST_WR);
   wire       a_ok      = (grp_a == ssf_pkg::GA_NONE) | (grp_a == ssf_pkg::GA_SHORT)
                        | (grp_a == ssf_pkg::GA_STATUS) | (grp_a == ssf_pkg::GA_ECHO)
                        | (grp_a == ssf_pkg::GA_INPUT);
   wire       b_ok      = (grp_b == ssf_pkg::GB_NONE) | (grp_b == ssf_pkg::GB_CLEAR);
   wire       cmd_valid = is_cmd & (rx_tag == ssf_pkg::CMD_TAG) & a_ok & b_ok;
   wire       cmd_bad   = is_cmd & ~cmd_valid;
   wire       frame_end = cs_rise & frame_ok;
   wire       mod_event = cs_rise & ~frame_ok;
   wire       link_event = frame_end & cmd_bad;
   wire       clr_status = frame_end & cmd_valid & (grp_b == ssf_pkg::GB_CLEAR);

   // Diagnosis flags and device status byte
   wire [9:0] fault_flags = diag_open_load | diag_overcurrent | diag_overtemp;

   assign status_now.unused              = 2'h0;
   assign status_now.link_error_flag     = link_err_q;
   assign status_now.frame_counter_error = frame_cnt_err_q;
   assign status_now.analog_supply_low   = pins_s.uv_ana;
   assign status_now.digital_supply_low  = pins_s.uv_dig;
   assign status_now.fault_group_high    = |fault_flags[9:6];
   assign status_now.fault_group_low     = |fault_flags[5:0];

   wire [14:0] short_word  = {5'h00, fault_flags};
   wire [14:0] status_word = {7'h00, status_now};
   wire [14:0] input_word  = {5'h00, pins_s.par_in};

   // Response selection; a frame of the wrong length is not decoded and selects the zero answer
   always_comb
   begin
      resp_kind_d = ssf_pkg::RESP_ZERO;
      if (frame_ok && cmd_valid)
      begin
         case (grp_a)
            ssf_pkg::GA_SHORT:  resp_kind_d = ssf_pkg::RESP_SHORT;
            ssf_pkg::GA_STATUS: resp_kind_d = ssf_pkg::RESP_STATUS;
            ssf_pkg::GA_ECHO:   resp_kind_d = ssf_pkg::RESP_ECHO;
            ssf_pkg::GA_INPUT:  resp_kind_d = ssf_pkg::RESP_INPUT;
            default:            resp_kind_d = ssf_pkg::RESP_ZERO;
         endcase
      end
      else if (frame_ok && is_write)
      begin
         resp_kind_d = ssf_pkg::RESP_SHORT;
      end
   end

   wire [14:0] pend_word_d =
      (resp_kind_d == ssf_pkg::RESP_SHORT)  ? short_word  :
      (resp_kind_d == ssf_pkg::RESP_STATUS) ? status_word :
      (resp_kind_d == ssf_pkg::RESP_ECHO)   ? ssf_pkg::ECHO_WORD : 15'h0000;

   // Input levels are taken fresh at the start of the answer frame
   wire [15:0] load_frame = ssf_pkg::ssf_add_parity(
      (pend_kind_q == ssf_pkg::RESP_INPUT) ? input_word : pend_word_q);

   // Register port decode
   wire wr_stat = reg_wr & (reg_addr == ssf_pkg::REG_IRQ_STAT);
   wire wr_mask = reg_wr & (reg_addr == ssf_pkg::REG_IRQ_MASK);
   wire [3:0] irq_events = {uv_now & ~uv_prev_q, mod_event, link_event, frame_end};
   wire [15:0] rd_mux =
      (reg_addr == ssf_pkg::REG_IRQ_STAT) ? {12'h000, irq_stat_q} :
      (reg_addr == ssf_pkg::REG_IRQ_MASK) ? {12'h000, irq_mask_q} :
      (reg_addr == ssf_pkg::REG_LAST_RX)  ? rx_last_q :
      (reg_addr == ssf_pkg::REG_DEV_STAT) ? {8'h00, status_now} : 16'h0000;

   // Set wins over a write-one-to-clear in the same cycle
   assign irq_stat_d = (irq_stat_q & ~(wr_stat ? reg_wdata[3:0] : 4'h0)) | irq_events;

   // Edge history
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         sclk_prev_q <= 1'b0;
         cs_prev_q   <= 1'b1;
         uv_prev_q   <= 1'b0;
      end
      else
      begin
         sclk_prev_q <= pins_s.sclk;
         cs_prev_q   <= pins_s.cs_b;
         uv_prev_q   <= uv_now;
      end
   end

   // Receive shifter and bit counter; counter saturates to flag long frames
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         rx_q      <= ssf_pkg::WORD_RST;
         bit_cnt_q <= ssf_pkg::CNT_RST;
      end
      else if (cs_fall)
      begin
         bit_cnt_q <= ssf_pkg::CNT_RST;
      end
      else if (sclk_rise)
      begin
         rx_q      <= {rx_q[14:0], pins_s.si};
         bit_cnt_q <= bit_cnt_q + ((bit_cnt_q != ssf_pkg::CNT_SAT) ? 5'h01 : 5'h00);
      end
   end

   // Snapshot of the answer, taken when the command frame closes
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         pend_kind_q <= ssf_pkg::RESP_ZERO;
         pend_word_q <= 15'h0000;
         rx_last_q   <= ssf_pkg::WORD_RST;
      end
      else if (cs_rise)
      begin
         pend_kind_q <= resp_kind_d;
         pend_word_q <= pend_word_d;
         rx_last_q   <= frame_ok ? rx_q : rx_last_q;
      end
   end

   // Transmit shifter: answer goes out during the next frame
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         tx_q      <= ssf_pkg::WORD_RST;
         spi_so    <= 1'b0;
         spi_so_oe <= 1'b0;
      end
      else
      begin
         spi_so_oe <= in_frame;
         if (cs_fall)
         begin
            tx_q   <= load_frame;
            spi_so <= load_frame[15];
         end
         else if (sclk_fall)
         begin
            tx_q   <= {tx_q[14:0], 1'b0};
            spi_so <= tx_q[14];
         end
      end
   end

   // Communication error flags, cleared by the clear command group
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         frame_cnt_err_q <= 1'b0;
         link_err_q      <= 1'b0;
      end
      else
      begin
         frame_cnt_err_q <= mod_event | (frame_cnt_err_q & ~clr_status);
         link_err_q      <= link_event | (link_err_q & ~clr_status);
      end
   end

   // Interrupt status, mask, output and register read data
   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         irq_stat_q <= ssf_pkg::IRQ_RST;
         irq_mask_q <= ssf_pkg::IRQ_RST;
         irq        <= 1'b0;
         reg_rdata  <= ssf_pkg::WORD_RST;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_mask_q <= wr_mask ? reg_wdata[3:0] : irq_mask_q;
         irq        <= |(irq_stat_q & irq_mask_q);
         reg_rdata  <= reg_rd ? rd_mux : ssf_pkg::WORD_RST;
      end
   end

   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_SNAPSHOT_HOLDS:
      assert property (!cs_rise |=> $stable(pend_word_q) && $stable(pend_kind_q))
      else $error("Response snapshot changed outside frame end");

   AST_SHORT_LAYOUT:
      assert property (cs_rise && resp_kind_d == ssf_pkg::RESP_SHORT |=>
         pend_word_q == {5'h00, $past(diag_open_load | diag_overcurrent | diag_overtemp)})
      else $error("Short diagnosis payload wrong");

   AST_WRITE_SHORT:
      assert property (frame_end && rx_addr >= ssf_pkg::ADDR_FIRST_WR |=>
         pend_kind_q == ssf_pkg::RESP_SHORT)
      else $error("Write frame did not select short diagnosis");

   AST_STATUS_LAYOUT:
      assert property (cs_rise && resp_kind_d == ssf_pkg::RESP_STATUS |=>
         pend_word_q[14:6] == 9'h000
         && pend_word_q[0] == $past(|fault_flags[5:0])
         && pend_word_q[1] == $past(|fault_flags[9:6])
         && pend_word_q[2] == $past(pins_s.uv_dig)
         && pend_word_q[3] == $past(pins_s.uv_ana))
      else $error("Status payload wrong");

   AST_MOD_ERROR:
      assert property (mod_event |=> frame_cnt_err_q && pend_kind_q == ssf_pkg::RESP_ZERO)
      else $error("Wrong-length frame not recorded");

   AST_LINK_ERROR:
      assert property (link_event |=> link_err_q && pend_kind_q == ssf_pkg::RESP_ZERO
         ##1 status_now.link_error_flag)
      else $error("Bad command not ignored and recorded");

   AST_DECODE:
      assert property (frame_end && cmd_valid && grp_a == ssf_pkg::GA_ECHO |=>
         pend_kind_q == ssf_pkg::RESP_ECHO)
      else $error("Pattern check not decoded");

   AST_ECHO_WORD:
      assert property (cs_fall && pend_kind_q == ssf_pkg::RESP_ECHO |=>
         tx_q[14:0] == ssf_pkg::ECHO_WORD)
      else $error("Pattern echo wrong");

   AST_INPUT_SAMPLE:
      assert property (cs_fall && pend_kind_q == ssf_pkg::RESP_INPUT |=>
         tx_q == {^$past(pins_s.par_in), 5'h00, $past(pins_s.par_in)})
      else $error("Input readback not sampled at frame start");

   AST_PARITY_FIRST_BIT:
      assert property (cs_fall |=> tx_q[15] == ^tx_q[14:0] && spi_so == tx_q[15] && spi_so_oe)
      else $error("Parity or first output bit wrong");

   COV_INPUT_CMD:
      cover property (frame_end && cmd_valid && grp_a == ssf_pkg::GA_INPUT);
   COV_BAD_CMD:
      cover property (link_event);
   COV_ECHO_OUT:
      cover property (cs_fall && pend_kind_q == ssf_pkg::RESP_ECHO);

endmodule // ssf_feedback

// ### rtl/ssf_pkg.sv
// Constants, types and helpers for the SPI status feedback frame builder.
// Assumes a 16-bit SPI frame, MSB first, and ten output channels.
package ssf_pkg;

   // Frame geometry
   localparam int          FRAME_BITS   = 16;
   localparam int          CHANNELS     = 10;
   localparam logic [4:0]  CNT_RST      = 5'h00;
   localparam logic [4:0]  CNT_FULL     = 5'h10;
   localparam logic [4:0]  CNT_SAT      = 5'h1F;

   // Received command frame fields
   localparam logic [2:0]  ADDR_CMD     = 3'h0;
   localparam logic [2:0]  ADDR_FIRST_WR = 3'h2;
   localparam logic [3:0]  CMD_TAG      = 4'h7;
   localparam logic [3:0]  GA_NONE      = 4'h0;
   localparam logic [3:0]  GA_SHORT     = 4'h1;
   localparam logic [3:0]  GA_STATUS    = 4'h2;
   localparam logic [3:0]  GA_ECHO      = 4'h4;
   localparam logic [3:0]  GA_INPUT     = 4'h8;
   localparam logic [3:0]  GB_NONE      = 4'h0;
   localparam logic [3:0]  GB_CLEAR     = 4'h1;
   localparam logic [14:0] ECHO_WORD    = 15'h0704;

   // Register port offsets
   localparam logic [3:0]  REG_IRQ_STAT = 4'h0;
   localparam logic [3:0]  REG_IRQ_MASK = 4'h4;
   localparam logic [3:0]  REG_LAST_RX  = 4'h8;
   localparam logic [3:0]  REG_DEV_STAT = 4'hC;

   // Interrupt status bit positions and reset values
   localparam int          IRQ_FRAME    = 0;
   localparam int          IRQ_LINK     = 1;
   localparam int          IRQ_MOD      = 2;
   localparam int          IRQ_UV       = 3;
   localparam logic [3:0]  IRQ_RST      = 4'h0;
   localparam logic [15:0] WORD_RST     = 16'h0000;
   localparam logic [14:0] PINS_RST     = 15'h2000;

   typedef struct packed {
      logic       sclk;
      logic       cs_b;
      logic       si;
      logic       uv_dig;
      logic       uv_ana;
      logic [9:0] par_in;
   } ssf_pins_t;

   typedef struct packed {
      logic [1:0] unused;
      logic       link_error_flag;
      logic       frame_counter_error;
      logic       analog_supply_low;
      logic       digital_supply_low;
      logic       fault_group_high;
      logic       fault_group_low;
   } ssf_status_t;

   typedef enum logic [2:0] {
      RESP_ZERO,
      RESP_SHORT,
      RESP_STATUS,
      RESP_ECHO,
      RESP_INPUT
   } ssf_resp_t;

   // Even parity: the whole 16-bit frame carries an even count of ones
   function automatic logic [15:0] ssf_add_parity(input logic [14:0] payload);
      ssf_add_parity = {^payload, payload};
   endfunction

endpackage

// ### rtl/ssf_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level; no bus coherency is implied.
`timescale 1ns/100ps
module ssf_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // Levels
   input  wire logic [WIDTH-1:0] d,
   output      logic [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_b)
      begin
         meta_q <= RST_VAL;
         q      <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end

endmodule // ssf_sync

// ### tb/ssf_spi_master.sv
// SPI master model that sends command frames and collects serial answers.
// Assumes SPI mode 0, a 40 MHz clk_sys and a 200 ns SCLK period.
`timescale 1ns/100ps
module ssf_spi_master (
   // Clock
   input  wire logic clk_sys,
   // SPI pins
   input  wire logic so_pin,
   output      logic sclk,
   output      logic cs_b,
   output      logic si
);
   initial
   begin
      sclk = 1'b0;
      cs_b = 1'b1;
      si   = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Low phase is the longer one so that the 3-4 cycle SO update
   // settles before the rise at which the answer bit is taken
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      @(posedge clk_sys);
      cs_b <= 1'b0;
      for (int i = 0; i < nbits; i++)
      begin
         si <= tx[15-i];
         tick(5);
         sclk <= 1'b1;
         rx = {rx[14:0], so_pin};
         tick(3);
         sclk <= 1'b0;
      end
      tick(5);
      cs_b <= 1'b1;
      si   <= ~si;
      // Gap before the next frame, which carries this frame's answer
      tick(10);
   endtask
endmodule // ssf_spi_master

// ### tb/testbench.sv
// Self-checking bench for the SPI status feedback frame builder.
// Assumes the master model drives the SPI pins and tasks drive the register port.
`timescale 1ns/100ps
module testbench;
   logic        clk_sys   = 1'b0;
   logic        rst_b     = 1'b0;
   logic        spi_sclk;
   logic        spi_cs_b;
   logic        spi_si;
   logic        spi_so;
   logic        spi_so_oe;
   wire         so_pin;
   logic [9:0]  par_in    = 10'h000;
   logic [9:0]  open_l    = 10'h000;
   logic [9:0]  over_c    = 10'h000;
   logic [9:0]  over_t    = 10'h000;
   logic        uv_dig    = 1'b0;
   logic        uv_ana    = 1'b0;
   logic [3:0]  reg_addr  = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        reg_wr    = 1'b0;
   logic        reg_rd    = 1'b0;
   logic [15:0] reg_rdata;
   logic        irq;
   logic [15:0] rx;
   int          miscompares = 0;
   int          checked     = 0;

   always #12.5 clk_sys = ~clk_sys;

   // A released SO pin floats, so a read outside the drive window fails
   assign so_pin = spi_so_oe ? spi_so : 1'bz;

   ssf_feedback ssf_feedback_inst (
      .clk_sys                 (clk_sys),
      .rst_b                   (rst_b),
      .spi_sclk                (spi_sclk),
      .spi_cs_b                (spi_cs_b),
      .spi_si                  (spi_si),
      .spi_so                  (spi_so),
      .spi_so_oe               (spi_so_oe),
      .parallel_control_inputs (par_in),
      .supply_uv_digital       (uv_dig),
      .supply_uv_analog        (uv_ana),
      .diag_open_load          (open_l),
      .diag_overcurrent        (over_c),
      .diag_overtemp           (over_t),
      .reg_addr                (reg_addr),
      .reg_wdata               (reg_wdata),
      .reg_wr                  (reg_wr),
      .reg_rd                  (reg_rd),
      .reg_rdata               (reg_rdata),
      .irq                     (irq)
   );

   ssf_spi_master ssf_spi_master_inst (
      .clk_sys (clk_sys),
      .so_pin  (so_pin),
      .sclk    (spi_sclk),
      .cs_b    (spi_cs_b),
      .si      (spi_si)
   );

   task automatic end_of_test();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   function automatic logic [15:0] framed(input logic [14:0] p);
      framed = {^p, p};
   endfunction

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk_sys);
      reg_wr    <= 1'b0;
   endtask

   task automatic rchk(input logic [3:0] a, input logic [15:0] exp, input string what);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clk_sys);
      reg_rd   <= 1'b0;
      #1;
      chk(what, reg_rdata, exp);
   endtask

   task automatic exch(input logic [15:0] tx, input logic [15:0] exp);
      ssf_spi_master_inst.xfer(tx, 16, rx);
      chk("serial answer", rx, exp);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk_sys);
      miscompares++;
      end_of_test();
   end

   initial
   begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      rchk(4'h0, 16'h0000, "irq status");
      rchk(4'h4, 16'h0000, "irq mask");
      rchk(4'hC, 16'h0000, "device status");
      rchk(4'h2, 16'h0000, "unmapped read");
      chk("irq", {15'h0000, irq}, 16'h0000);
      open_l <= 10'h001;
      over_c <= 10'h200;
      over_t <= 10'h010;
      exch(16'h0701, 16'h0000);
      // Inputs move after the snapshot; the answer must not follow them
      open_l <= 10'h000;
      over_t <= 10'h3FF;
      uv_dig <= 1'b1;
      exch(16'h0702, framed(15'h0211));
      over_t <= 10'h000;
      over_c <= 10'h000;
      open_l <= 10'h020;
      uv_dig <= 1'b0;
      uv_ana <= 1'b1;
      exch(16'h0702, framed(15'h0007));
      open_l <= 10'h040;
      uv_ana <= 1'b0;
      exch(16'h0702, framed(15'h0009));
      exch(16'h0704, framed(15'h0002));
      par_in <= 10'h2A5;
      exch(16'h0708, framed(15'h0704));
      par_in <= 10'h155;
      fork
         exch(16'h2C00, framed(15'h0155));
         begin
            repeat (30) @(posedge clk_sys);
            par_in <= 10'h3FF;
         end
      join
      exch(16'h0700, framed(15'h0040));
      exch(16'h0703, 16'h0000);
      exch(16'h0702, 16'h0000);
      exch(16'h0710, framed(15'h0022));
      ssf_spi_master_inst.xfer(16'h0702, 8, rx);
      exch(16'h0702, 16'h0000);
      exch(16'h0700, framed(15'h0012));
      rchk(4'hC, 16'h0012, "device status");
      rchk(4'h8, 16'h0700, "last frame");
      rchk(4'h0, 16'h000F, "irq status");
      chk("irq", {15'h0000, irq}, 16'h0000);
      wr(4'h4, 16'h0002);
      rchk(4'h4, 16'h0002, "irq mask");
      chk("irq", {15'h0000, irq}, 16'h0001);
      wr(4'h0, 16'h0002);
      rchk(4'h0, 16'h000D, "irq status");
      chk("irq", {15'h0000, irq}, 16'h0000);
      wr(4'h2, 16'hFFFF);
      rchk(4'h4, 16'h0002, "irq mask");
      end_of_test();
   end
endmodule // testbench
